// ### hdl/lbps_seq.sv
// Power-up sequencer and reset generator for a display bias supply
// Operation
// - Logic rail, then gate low, then gate high/source
// - Logic converter enabled at undervoltage release or over-temperature recovery
// - Power-good starts reset timer; expiry releases reset, gate-low
// - Delay timer starts with gate-low pump enable
// - Undervoltage drops every output at once
// - Isolation gate low one delay after reset high
// - 1 ms after gate low, source good enables boost
// - Source not up by 1 ms flags error
// - Pump short-circuit mode starts with gate low
// - Feedback at 100 mV pauses pump drive
// - Boost switching moves pump to normal regulation
// - Pump current limit ramps up gradually
// - Reset output open-drain, only pulls low
// - Reset length starts at power-good, programmed
// - Reset pin state never blocks later start-up
// - Zero reset interval proceeds immediately
// - External enable gates gate-low pump start
// - External enable: isolation gate low one delay after rise, boost after the check window
// - Undervoltage lockout holds device inactive
// - Over-temperature disables outputs, resumes after cooling
module lbps_seq
    import lbps_pkg::*;
#(
    parameter int unsigned CHECK_CYC = CHECK_CYCLES
)
(
    input  wire logic                  clk_i,
    input  wire logic                  srst_i,
    input  wire logic                  input_supply_ok_i,
    input  wire logic                  logic_rail_pgood_i,
    input  wire logic                  source_rail_ok_i,
    input  wire logic                  pos_pump_feedback_ok_i,
    input  wire logic                  over_temp_i,
    input  wire logic                  ext_enable_mode_i,
    input  wire logic                  ext_enable_i,
    input  wire logic [CNT_W-1:0]      reset_interval_cap_i,
    input  wire logic [CNT_W-1:0]      delay_interval_cap_i,
    output lbps_pkg::lbps_rails_t      rails_o,
    output logic                       tcon_reset_n_o,
    output logic                       tcon_reset_oe_o,
    output logic                       isolation_gate_n_o,
    output logic                       pos_pump_sc_mode_o,
    output logic                       pos_pump_drive_en_o,
    output logic [SOFT_W-1:0]          pos_pump_ilimit_o,
    output logic                       source_error_o
);
    import lbps_pkg::*;

    // Pin-side inputs pass two flops before use
    logic [6:0] sync1_q, sync2_q;
    logic       vin_ok, pgood, vs_ok, fbp_ok;
    logic       otp, ext_mode, ext_en;

    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            sync1_q <= 7'h00;
            sync2_q <= 7'h00;
        end
        else
        begin
            sync1_q <= {input_supply_ok_i, logic_rail_pgood_i, source_rail_ok_i,
                        pos_pump_feedback_ok_i, over_temp_i, ext_enable_mode_i,
                        ext_enable_i};
            sync2_q <= sync1_q;
        end
    end

    assign vin_ok   = sync2_q[6];
    assign pgood    = sync2_q[5];
    assign vs_ok    = sync2_q[4];
    assign fbp_ok   = sync2_q[3];
    assign otp      = sync2_q[2];
    assign ext_mode = sync2_q[1];
    assign ext_en   = sync2_q[0];

    // Thermal shutdown is treated like undervoltage: a full restart on recovery
    logic alive;
    assign alive = vin_ok && !otp;

    lbps_state_t       st_q, st_d;
    logic [CNT_W-1:0]  chk_q, chk_d;
    logic              err_q, err_d;
    logic              boosted_q, boosted_d;
    logic [SOFT_W-1:0] soft_q, soft_d;
    logic [4:0]        step_q, step_d;
    logic              hold_q, hold_d;
    lbps_rails_t       rails_q, rails_d;
    logic              rst_n_q, rst_n_d;
    logic              gd_n_q, gd_n_d;
    logic              sc_q, sc_d;
    logic              drv_q, drv_d;

    logic rst_start, dly_start;
    logic rst_done, dly_done;

    // Reset interval timer, started by power-good
    lbps_timer #(.W(CNT_W)) u_rst_tmr
    (
        .clk_i   (clk_i),
        .srst_i  (srst_i),
        .start_i (rst_start),
        .load_i  (reset_interval_cap_i),
        .done_o  (rst_done)
    );

    // Delay interval timer, started with the gate-low pump
    lbps_timer #(.W(CNT_W)) u_dly_tmr
    (
        .clk_i   (clk_i),
        .srst_i  (srst_i),
        .start_i (dly_start),
        .load_i  (delay_interval_cap_i),
        .done_o  (dly_done)
    );

    always_comb
    begin
        st_d      = st_q;
        chk_d     = chk_q;
        err_d     = err_q;
        boosted_d = boosted_q;
        rails_d   = rails_q;
        rst_n_d   = rst_n_q;
        gd_n_d    = gd_n_q;
        sc_d      = sc_q;
        drv_d     = drv_q;
        hold_d    = hold_q;
        rst_start = 1'b0;
        dly_start = 1'b0;
        if (!alive)
        begin
            // No ordered shutdown: everything drops together
            st_d      = ST_OFF;
            rails_d   = RAILS_OFF;
            rst_n_d   = 1'b0;
            gd_n_d    = 1'b1;
            sc_d      = 1'b0;
            drv_d     = 1'b0;
            hold_d    = 1'b0;
            boosted_d = 1'b0;
            err_d     = 1'b0;
            chk_d     = CNT_RESET;
        end
        else
        begin
            case (st_q)
                ST_OFF:
                begin
                    rails_d.logic_rail_en = 1'b1;
                    if (pgood && !ext_mode)
                    begin
                        rst_start = 1'b1;
                        st_d      = ST_RST_WAIT;
                    end
                    else if (pgood && ext_mode && ext_en)
                    begin
                        // A level test, so an enable that is already high still starts
                        rails_d.gate_low_rail_en = 1'b1;
                        rst_n_d   = 1'b1;
                        dly_start = 1'b1;
                        st_d      = ST_DLY_WAIT;
                    end
                end
                ST_RST_WAIT:
                begin
                    if (rst_done)
                    begin
                        rst_n_d                  = 1'b1;
                        rails_d.gate_low_rail_en = 1'b1;
                        dly_start                = 1'b1;
                        st_d                     = ST_DLY_WAIT;
                    end
                end
                ST_DLY_WAIT:
                begin
                    if (dly_done)
                    begin
                        gd_n_d = 1'b0;
                        sc_d   = 1'b1;
                        drv_d  = 1'b1;
                        chk_d  = CNT_W'(CHECK_CYC);
                        st_d   = ST_CHECK;
                    end
                end
                ST_CHECK:
                begin
                    if (chk_q <= CNT_W'(1))
                    begin
                        if (vs_ok)
                        begin
                            rails_d.boost_en          = 1'b1;
                            rails_d.gate_high_rail_en = 1'b1;
                            boosted_d                 = 1'b1;
                            st_d                      = ST_RUN;
                        end
                        else
                        begin
                            err_d = 1'b1;
                            st_d  = ST_FAULT;
                        end
                        chk_d = CNT_RESET;
                    end
                    else
                    begin
                        chk_d = chk_q - CNT_W'(1);
                    end
                end
                ST_RUN:
                begin
                    sc_d   = 1'b0;
                    hold_d = 1'b0;
                end
                default:
                begin
                    // Latched until power is lost or over-temperature; boost stays off
                    rails_d.boost_en = 1'b0;
                end
            endcase
            // Short-circuit mode: stop sourcing once feedback shows no short
            if (sc_q && fbp_ok && !boosted_q)
            begin
                hold_d = 1'b1;
            end
            drv_d = (st_d == ST_CHECK || st_d == ST_FAULT || st_d == ST_RUN)
                    && !hold_d;
        end
    end

    // Soft-start: the current limit climbs one step every few cycles
    always_comb
    begin
        soft_d = soft_q;
        step_d = step_q;
        if (!alive || st_q != ST_RUN)
        begin
            soft_d = SOFT_RESET;
            step_d = 5'h00;
        end
        else if (soft_q != SOFT_FULL)
        begin
            if (step_q == 5'(SOFT_STEP_CYC - 1))
            begin
                step_d = 5'h00;
                soft_d = soft_q + SOFT_W'(1);
            end
            else
            begin
                step_d = step_q + 5'h01;
            end
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            st_q      <= ST_OFF;
            chk_q     <= CNT_RESET;
            err_q     <= 1'b0;
            boosted_q <= 1'b0;
            rails_q   <= RAILS_OFF;
            rst_n_q   <= 1'b0;
            gd_n_q    <= 1'b1;
            sc_q      <= 1'b0;
            drv_q     <= 1'b0;
            hold_q    <= 1'b0;
            soft_q    <= SOFT_RESET;
            step_q    <= 5'h00;
        end
        else
        begin
            st_q      <= st_d;
            chk_q     <= chk_d;
            err_q     <= err_d;
            boosted_q <= boosted_d;
            rails_q   <= rails_d;
            rst_n_q   <= rst_n_d;
            gd_n_q    <= gd_n_d;
            sc_q      <= sc_d;
            drv_q     <= drv_d;
            hold_q    <= hold_d;
            soft_q    <= soft_d;
            step_q    <= step_d;
        end
    end

    // Open-drain reset: data pin always low, enable pulls while in reset
    assign rails_o             = rails_q;
    assign tcon_reset_n_o      = 1'b0;
    assign tcon_reset_oe_o     = !rst_n_q;
    assign isolation_gate_n_o  = gd_n_q;
    assign pos_pump_sc_mode_o  = sc_q;
    assign pos_pump_drive_en_o = drv_q;
    assign pos_pump_ilimit_o   = soft_q;
    assign source_error_o      = err_q;

    order_a: assert property (@(posedge clk_i) disable iff (srst_i)
        rails_q.gate_high_rail_en |-> rails_q.gate_low_rail_en && rails_q.logic_rail_en)
        else $error("gate high rail up before lower rails");
    undervoltage_lockout_drop_a: assert property (@(posedge clk_i) disable iff (srst_i)
        !alive |=> rails_q == RAILS_OFF && gd_n_q)
        else $error("outputs not dropped on undervoltage");
    gl_with_rst_a: assert property (@(posedge clk_i) disable iff (srst_i)
        $rose(rst_n_q) |-> $rose(rails_q.gate_low_rail_en))
        else $error("gate low pump not enabled with reset release");
    gd_sc_a: assert property (@(posedge clk_i) disable iff (srst_i)
        $fell(gd_n_q) |-> sc_q)
        else $error("short-circuit mode not set with isolation gate");
    boost_ok_a: assert property (@(posedge clk_i) disable iff (srst_i)
        $rose(rails_q.boost_en) |-> !gd_n_q && $past(vs_ok))
        else $error("boost enabled without source rail good");
    err_block_a: assert property (@(posedge clk_i) disable iff (srst_i)
        err_q |-> !rails_q.boost_en)
        else $error("boost enabled while error latched");
    err_hold_a: assert property (@(posedge clk_i) disable iff (srst_i)
        err_q && alive |=> err_q)
        else $error("error flag cleared without restart");
    od_a: assert property (@(posedge clk_i) disable iff (srst_i)
        !tcon_reset_n_o)
        else $error("reset pin driven high");
    soft_a: assert property (@(posedge clk_i) disable iff (srst_i)
        st_q == ST_RUN && $past(st_q) == ST_RUN |-> soft_q - $past(soft_q) <= SOFT_W'(1))
        else $error("pump current limit stepped too fast");
    hold_a: assert property (@(posedge clk_i) disable iff (srst_i)
        alive && sc_q && fbp_ok && !boosted_q |=> hold_q && !drv_q)
        else $error("pump drive not paused on feedback");
endmodule

// ### hdl/lbps_pkg.sv
// Shared constants and types for the display bias power sequencer
package lbps_pkg;

    localparam int unsigned CLK_HZ          = 10_000_000;
    localparam int unsigned CHECK_WINDOW_US = 1000;
    localparam int unsigned CHECK_CYCLES    = (CHECK_WINDOW_US * (CLK_HZ / 1_000_000));
    localparam int unsigned CNT_W           = 24;
    localparam int unsigned SOFT_W          = 8;
    localparam int unsigned SOFT_STEP_CYC   = 16;

    localparam logic [CNT_W-1:0]  CNT_RESET   = 24'h000000;
    localparam logic [SOFT_W-1:0] SOFT_RESET  = 8'h00;
    localparam logic [SOFT_W-1:0] SOFT_FULL   = 8'hff;

    typedef enum logic [2:0]
    {
        ST_OFF      = 3'b000,
        ST_RST_WAIT = 3'b001,
        ST_DLY_WAIT = 3'b010,
        ST_CHECK    = 3'b011,
        ST_RUN      = 3'b100,
        ST_FAULT    = 3'b101
    } lbps_state_t;

    // Converter and pump enables, grouped as they leave the block
    typedef struct packed
    {
        logic logic_rail_en;
        logic gate_low_rail_en;
        logic boost_en;
        logic gate_high_rail_en;
    } lbps_rails_t;

    localparam lbps_rails_t RAILS_OFF = '{1'b0, 1'b0, 1'b0, 1'b0};

endpackage

// ### hdl/lbps_timer.sv
// Loadable down-counter that stands in for a capacitor ramp timer
module lbps_timer
#(
    parameter int unsigned W = 24
)
(
    input  wire logic         clk_i,
    input  wire logic         srst_i,
    input  wire logic         start_i,
    input  wire logic [W-1:0] load_i,
    output logic              done_o
);
    logic [W-1:0] cnt_q;
    logic [W-1:0] cnt_d;
    logic         run_q;
    logic         run_d;
    logic         done_q;
    logic         done_d;

    always_comb
    begin
        cnt_d  = cnt_q;
        run_d  = run_q;
        done_d = 1'b0;
        if (start_i)
        begin
            // A zero load means no capacitor: finish on the next edge
            cnt_d  = load_i;
            run_d  = (load_i != '0);
            done_d = (load_i == '0);
        end
        else if (run_q)
        begin
            if (cnt_q <= W'(1))
            begin
                run_d  = 1'b0;
                done_d = 1'b1;
                cnt_d  = '0;
            end
            else
            begin
                cnt_d = cnt_q - W'(1);
            end
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            cnt_q  <= '0;
            run_q  <= 1'b0;
            done_q <= 1'b0;
        end
        else
        begin
            cnt_q  <= cnt_d;
            run_q  <= run_d;
            done_q <= done_d;
        end
    end

    assign done_o = done_q;
endmodule

// ### tb/lbps_partner_model.sv
// Behavioural converters, pumps and reset pull-up facing the sequencer
module lbps_partner_model
(
    input  wire logic                  clk_i,
    input  wire lbps_pkg::lbps_rails_t rails_i,
    input  wire logic                  tcon_reset_n_i,
    input  wire logic                  tcon_reset_oe_i,
    input  wire logic                  isolation_gate_n_i,
    input  wire logic                  pos_pump_sc_mode_i,
    input  wire logic                  source_stuck_i,
    input  wire logic [7:0]            pg_dly_i,
    output logic                       logic_rail_pgood_o,
    output logic                       source_rail_ok_o,
    output logic                       pos_pump_feedback_ok_o,
    output logic                       tcon_reset_line_o
);
    timeunit 1ns;
    timeprecision 1ns;
    import lbps_pkg::*;
    localparam int SRC_DLY = 5;
    localparam int FB_DLY  = 3;
    int pg_cnt = 0;
    int src_cnt = 0;
    int fb_cnt = 0;

    // Rails collapse at once when their enable drops
    always @(posedge clk_i)
    begin
        pg_cnt  <= rails_i.logic_rail_en ? pg_cnt + 1 : 0;
        src_cnt <= (!isolation_gate_n_i && !source_stuck_i) ? src_cnt + 1 : 0;
        fb_cnt  <= pos_pump_sc_mode_i ? fb_cnt + 1 : 0;
    end

    assign logic_rail_pgood_o     = pg_cnt > int'(pg_dly_i);
    assign source_rail_ok_o       = src_cnt > SRC_DLY;
    assign pos_pump_feedback_ok_o = fb_cnt > FB_DLY;
    // Board pull-up wins whenever the pin is released
    assign tcon_reset_line_o = tcon_reset_oe_i ? tcon_reset_n_i : 1'b1;
endmodule

// ### tb/lbps_seq_tb_top.sv
// Self-checking bench for the display bias power sequencer
module lbps_seq_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import lbps_pkg::*;
    localparam int CHK = 20;
    typedef struct {int rc; int dc; bit stuck; bit ext; int pg;} lbps_row_t;
    lbps_row_t rows[4] = '{'{0, 5, 0, 0, 2}, '{7, 3, 0, 0, 9}, '{3, 2, 1, 0, 4},
                           '{4, 6, 0, 1, 4}};
    logic clk_i = 0, srst_i = 1, sup = 0, ot = 0, xmode = 0, xen = 0, stuck = 0;
    logic [CNT_W-1:0] rc = '0, dc = '0;
    logic [7:0] pgd = 8'h04;
    logic pgood, src_ok, fb_ok, rst_line, rst_n, rst_oe, gd_n, sc, drv, err, drv_hold;
    lbps_rails_t rails, rl_p;
    logic [SOFT_W-1:0] ilim, il_a;
    int n_fail = 0, checks = 0, cyc = 0;
    int t_sup, t_lg, t_pg, t_rst, t_gl, t_gd, t_sc, t_bst, t_gh, t_x;
    logic oe_p = 1, gd_p = 1, sc_p = 0, pg_p = 0, sup_p = 0, x_p = 0;

    lbps_seq #(.CHECK_CYC(CHK)) u_dut (.clk_i(clk_i), .srst_i(srst_i),
        .input_supply_ok_i(sup), .logic_rail_pgood_i(pgood), .source_rail_ok_i(src_ok),
        .pos_pump_feedback_ok_i(fb_ok), .over_temp_i(ot), .ext_enable_mode_i(xmode),
        .ext_enable_i(xen), .reset_interval_cap_i(rc), .delay_interval_cap_i(dc),
        .rails_o(rails), .tcon_reset_n_o(rst_n), .tcon_reset_oe_o(rst_oe),
        .isolation_gate_n_o(gd_n), .pos_pump_sc_mode_o(sc), .pos_pump_drive_en_o(drv),
        .pos_pump_ilimit_o(ilim), .source_error_o(err));

    lbps_partner_model u_far (.clk_i(clk_i), .rails_i(rails), .tcon_reset_n_i(rst_n),
        .tcon_reset_oe_i(rst_oe), .isolation_gate_n_i(gd_n), .pos_pump_sc_mode_i(sc),
        .source_stuck_i(stuck), .pg_dly_i(pgd), .logic_rail_pgood_o(pgood),
        .source_rail_ok_o(src_ok), .pos_pump_feedback_ok_o(fb_ok),
        .tcon_reset_line_o(rst_line));

    always #50 clk_i = ~clk_i;

    // Edge monitor: every design output is seen one edge late, so spans stay exact
    always @(posedge clk_i)
    begin
        cyc <= cyc + 1;
        if (sup && !sup_p) t_sup = cyc;
        if (rails.logic_rail_en && !rl_p.logic_rail_en) t_lg = cyc;
        if (rails.gate_low_rail_en && !rl_p.gate_low_rail_en) t_gl = cyc;
        if (rails.boost_en && !rl_p.boost_en) t_bst = cyc;
        if (rails.gate_high_rail_en && !rl_p.gate_high_rail_en) t_gh = cyc;
        if (pgood && !pg_p) t_pg = cyc;
        if (!rst_oe && oe_p) t_rst = cyc;
        if (!gd_n && gd_p) t_gd = cyc;
        if (sc && !sc_p) t_sc = cyc;
        if (xen && !x_p) t_x = cyc;
        if (cyc == t_gd + 12) drv_hold = drv;
        {rl_p, oe_p, gd_p, sc_p, pg_p, sup_p, x_p} = {rails, rst_oe, gd_n, sc, pgood, sup, xen};
        if (cyc == 20000)
        begin
            n_fail++;
            end_sim();
        end
    end

    function automatic logic in_rng(int d, int lo, int hi);
        return d >= lo && d <= hi;
    endfunction

    task automatic chk(logic [31:0] seen, logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic tick(int n);
        repeat (n) @(posedge clk_i);
    endtask

    task automatic end_sim;
        $display("TB: checks=%0d n_fail=%0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic run(lbps_row_t r);
        int i;
        tick(1);
        rc <= CNT_W'(r.rc);
        dc <= CNT_W'(r.dc);
        stuck <= r.stuck;
        xmode <= r.ext;
        pgd <= 8'(r.pg);
        sup <= 1;
        if (r.ext)
        begin
            tick(30);
            #1;
            chk(rails.gate_low_rail_en, 0);
            chk(rails.logic_rail_en, 1);
            tick(1);
            xen <= 1;
        end
        for (i = 0; i < 600 && rails.boost_en !== 1 && err !== 1; i++) tick(1);
        tick(2);
        #1;
        il_a = ilim;
        chk(in_rng(t_lg - t_sup, 1, 4), 1);
        chk(t_gl, t_rst);
        if (r.ext) chk(in_rng(t_rst - t_x, 0, 3), 1);
        // Two sync flops, the timer load and the state step sit on top of the count
        else chk(in_rng(t_rst - t_pg, r.rc + 3, r.rc + 5), 1);
        chk(in_rng(t_gd - t_rst, r.dc, r.dc + 3), 1);
        chk(t_sc, t_gd);
        chk(drv_hold, 0);
        chk(rst_n, 0);
        chk(rst_line, 1);
        chk(rails.boost_en, !r.stuck);
        if (!r.stuck) chk(t_lg < t_gl && t_gl < t_bst && t_gh == t_bst, 1);
        if (!r.stuck) chk(in_rng(t_bst - t_gd, CHK, CHK + 3), 1);
        tick(48);
        #1;
        chk(err, r.stuck);
        chk(sc, r.stuck);
        if (!r.stuck) chk(drv, 1);
        if (!r.stuck) chk(in_rng(ilim - il_a, 2, 3), 1);
        tick(1);
        sup <= 0;
        xen <= 0;
        tick(4);
        #1;
        chk(rails, RAILS_OFF);
        chk({rst_oe, gd_n, err, rst_line}, 4'hc);
        tick(10);
    endtask

    initial
    begin
        tick(20);
        #1;
        chk({rails, rst_oe, gd_n, sc, drv, err, ilim}, {RAILS_OFF, 5'h18, 8'h00});
        tick(1);
        srst_i <= 0;
        foreach (rows[k]) run(rows[k]);
        // Over-temperature early in the delay, just after the gate-low rail rises, then recovery
        tick(1);
        rc <= CNT_W'(2);
        dc <= CNT_W'(30);
        xmode <= 0;
        sup <= 1;
        for (int i = 0; i < 100 && rails.gate_low_rail_en !== 1; i++) tick(1);
        ot <= 1;
        tick(4);
        #1;
        chk({rails, gd_n, rst_oe}, {RAILS_OFF, 2'h3});
        tick(1);
        ot <= 0;
        tick(6);
        #1;
        chk(rails.logic_rail_en, 1);
        // Reset during the restart, before power-good, with the supply still good: a clean restart follows
        tick(1);
        srst_i <= 1;
        tick(3);
        #1;
        chk({rails, rst_oe, gd_n, sc, drv, err, ilim}, {RAILS_OFF, 5'h18, 8'h00});
        tick(1);
        srst_i <= 0;
        tick(4);
        #1;
        chk(rails, 4'h8);
        end_sim();
    end
endmodule
